// file: design/dac_serial_pkg.sv
/*
 * Shared constants and carriers for the stereo serial sample input.
 * Assumes a 40 MHz system clock that is at least four times the bit clock.
 */
package dac_serial_pkg;

   // -----------------------------------------------------------------
   // Sizes, counts and reset values
   // -----------------------------------------------------------------
   localparam int          SAMPLE_BITS       = 16;
   localparam int          FIFO_DEPTH        = 32;
   localparam int          MCLK_HZ           = 40_000_000;
   localparam int          BCLK_MAX_HZ       = 10_000_000;
   localparam int          MIN_MCLK_PER_BCLK = 4;
   // 4.5 bit clocks after a word ends, counted in bit clock half periods
   localparam int          UPDATE_HALF_EDGES = 9;
   localparam logic [15:0] SAMPLE_RESET      = 16'h0000;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic bclk;
      logic strobe;
      logic data_l;
      logic pol_or_r;
      logic fmt;
   } pins_t;

   typedef struct packed {
      logic [SAMPLE_BITS-1:0] left;
      logic [SAMPLE_BITS-1:0] right;
   } pair_t;

endpackage : dac_serial_pkg

// file: design/stereo_dac_serial_input.sv
/*
 * Serial sample receiver with a pair FIFO and an in-phase output stage.
 * Assumes the five link pins are asynchronous to i_mclk and the bit clock is slow
 * enough that each of its levels lasts several i_mclk cycles.
 */
`timescale 1ns/1ps

// -----------------------------------------------------------------------
// Pair FIFO
// -----------------------------------------------------------------------
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("sample_fifo depth must be a power of two, at least 2");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr_ptr;
      logic [AW:0]                 rd_ptr;
   } fifo_state_t;
   fifo_state_t st_reg;
   fifo_state_t st_next;
   logic        full;
   logic        empty;
   // Extra pointer bit tells full from empty
   assign full        = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) &&
                        (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
   assign empty       = (st_reg.wr_ptr == st_reg.rd_ptr);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

   // Push and pop may happen in the same cycle
   always_comb
   begin
      st_next = st_reg;
      if (i_in_valid && !full)
      begin
         st_next.mem[st_reg.wr_ptr[AW-1:0]] = i_in_data;
         st_next.wr_ptr                     = st_reg.wr_ptr + 1'b1;
      end
      if (i_out_ready && !empty)
      begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
endmodule : sample_fifo

// -----------------------------------------------------------------------
// Serial input front end
// -----------------------------------------------------------------------
module stereo_dac_serial_input #(
   parameter int SAMPLE_BITS       = dac_serial_pkg::SAMPLE_BITS,
   parameter int FIFO_DEPTH        = dac_serial_pkg::FIFO_DEPTH,
   parameter int UPDATE_HALF_EDGES = dac_serial_pkg::UPDATE_HALF_EDGES
) (
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst,
   input  wire logic                   i_bit_clock,
   input  wire logic                   i_channel_word_strobe,
   input  wire logic                   i_shared_or_left_serial_input,
   input  wire logic                   i_polarity_or_right_input,
   input  wire logic                   i_format_select,
   input  wire logic                   i_dac_ready,
   output logic      [SAMPLE_BITS-1:0] o_left_sample,
   output logic      [SAMPLE_BITS-1:0] o_right_sample,
   output logic                        o_update,
   output logic                        o_overrun
);
   localparam int CW = $clog2(UPDATE_HALF_EDGES + 1);

   if (SAMPLE_BITS != dac_serial_pkg::SAMPLE_BITS || UPDATE_HALF_EDGES < 1 ||
       dac_serial_pkg::MCLK_HZ < dac_serial_pkg::MIN_MCLK_PER_BCLK * dac_serial_pkg::BCLK_MAX_HZ)
   begin : g_bad_params
      $error("stereo_dac_serial_input parameters not supported");
   end

   typedef struct packed {
      dac_serial_pkg::pins_t  sync1;
      dac_serial_pkg::pins_t  sync2;
      logic                   bclk_prev;
      logic                   strobe_prev;
      logic                   primed;
      logic [SAMPLE_BITS-1:0] shift_l;
      logic [SAMPLE_BITS-1:0] shift_r;
      logic [SAMPLE_BITS-1:0] hold_left;
      dac_serial_pkg::pair_t  pend;
      logic                   pend_valid;
      dac_serial_pkg::pair_t  head;
      logic                   busy;
      logic [CW-1:0]          edge_cnt;
      logic [SAMPLE_BITS-1:0] left_out;
      logic [SAMPLE_BITS-1:0] right_out;
      logic                   update;
      logic                   overrun;
   } top_state_t;

   top_state_t            st_reg;
   top_state_t            st_next;
   logic                  rise;
   logic                  fall;
   logic                  shared_end;
   logic                  sep_end;
   logic                  left_slot;
   logic                  push_req;
   logic                  blocked;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_pop;
   dac_serial_pkg::pair_t fifo_data;

   // Edge and word-end decode, all from the second synchroniser stage
   assign rise       = st_reg.sync2.bclk && !st_reg.bclk_prev;
   assign fall       = !st_reg.sync2.bclk && st_reg.bclk_prev;
   assign shared_end = rise && st_reg.primed && !st_reg.sync2.fmt && (st_reg.sync2.strobe != st_reg.strobe_prev);
   assign sep_end    = rise && st_reg.primed && st_reg.sync2.fmt && st_reg.strobe_prev && !st_reg.sync2.strobe;
   assign left_slot  = st_reg.strobe_prev ^ st_reg.sync2.pol_or_r;
   assign push_req   = (shared_end && !left_slot) || sep_end;
   assign blocked    = st_reg.pend_valid && !fifo_in_ready;
   assign fifo_pop   = fifo_out_valid && !st_reg.busy && i_dac_ready;

   sample_fifo #(
      .WIDTH (2 * SAMPLE_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_valid  (st_reg.pend_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (st_reg.pend),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_data)
   );

   // Next state: synchronise, shift, route words, drain with delay
   always_comb
   begin
      st_next           = st_reg;
      st_next.sync1     = {i_bit_clock, i_channel_word_strobe, i_shared_or_left_serial_input,
                           i_polarity_or_right_input, i_format_select};
      st_next.sync2     = st_reg.sync1;
      st_next.bclk_prev = st_reg.sync2.bclk;
      st_next.update    = 1'b0;
      st_next.overrun   = 1'b0;
      if (st_reg.pend_valid && fifo_in_ready)
         st_next.pend_valid = 1'b0;
      // History follows the pin until the first rise, so reset cannot fake a word end
      if (rise || !st_reg.primed)
         st_next.strobe_prev = st_reg.sync2.strobe;
      if (rise)
      begin
         st_next.primed = 1'b1;
         if (shared_end && left_slot)
            st_next.hold_left = st_reg.shift_l;
         if (push_req)
         begin
            // source cannot wait, so a blocked pair is lost and flagged
            if (blocked)
               st_next.overrun = 1'b1;
            else
            begin
               st_next.pend_valid = 1'b1;
               st_next.pend.left  = sep_end ? st_reg.shift_l : st_reg.hold_left;
               st_next.pend.right = sep_end ? st_reg.shift_r : st_reg.shift_l;
            end
         end
         st_next.shift_l = {st_reg.shift_l[SAMPLE_BITS-2:0], st_reg.sync2.data_l};
         st_next.shift_r = {st_reg.shift_r[SAMPLE_BITS-2:0], st_reg.sync2.pol_or_r};
      end
      if (fifo_pop)
      begin
         st_next.head     = fifo_data;
         st_next.busy     = 1'b1;
         st_next.edge_cnt = '0;
      end
      else if (st_reg.busy && (rise || fall))
      begin
         if (st_reg.edge_cnt == CW'(UPDATE_HALF_EDGES - 1))
         begin
            st_next.left_out  = st_reg.head.left;
            st_next.right_out = st_reg.head.right;
            st_next.update    = 1'b1;
            st_next.busy      = 1'b0;
         end
         else
            st_next.edge_cnt = st_reg.edge_cnt + 1'b1;
      end
   end

   // State register; no clock enable
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st_reg           <= '0;
         st_reg.left_out  <= dac_serial_pkg::SAMPLE_RESET;
         st_reg.right_out <= dac_serial_pkg::SAMPLE_RESET;
      end
      else
         st_reg <= st_next;
   end

   assign o_left_sample  = st_reg.left_out;
   assign o_right_sample = st_reg.right_out;
   assign o_update       = st_reg.update;
   assign o_overrun      = st_reg.overrun;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_pop_start;
      fifo_pop ##1 st_reg.busy;
   endsequence
   property p_shift_in;
      rise |=> st_reg.shift_l == {$past(st_reg.shift_l[SAMPLE_BITS-2:0]), $past(st_reg.sync2.data_l)};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("bit not shifted on rise");
   property p_shift_hold;
      !rise |=> $stable(st_reg.shift_l) && $stable(st_reg.shift_r);
   endproperty
   a_shift_hold: assert property (p_shift_hold) else $error("shift moved without rise");
   property p_left_slot;
      shared_end && left_slot |=> st_reg.hold_left == $past(st_reg.shift_l);
   endproperty
   a_left_slot: assert property (p_left_slot) else $error("left word not held");
   property p_shared_pair;
      shared_end && !left_slot && !blocked |=>
         st_reg.pend_valid && st_reg.pend.right == $past(st_reg.shift_l) &&
         st_reg.pend.left == $past(st_reg.hold_left);
   endproperty
   a_shared_pair: assert property (p_shared_pair) else $error("shared pair wrong");
   property p_sep_pair;
      sep_end && !blocked |=> st_reg.pend_valid && st_reg.pend.left == $past(st_reg.shift_l) &&
         st_reg.pend.right == $past(st_reg.shift_r);
   endproperty
   a_sep_pair: assert property (p_sep_pair) else $error("separate pair wrong");
   property p_overrun;
      push_req && blocked |=> o_overrun ##1 !o_overrun;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");
   // Nine counted edges need at least nine cycles, so eight quiet cycles are safe
   property p_delay;
      s_pop_start |-> !o_update [*8];
   endproperty
   a_delay: assert property (p_delay) else $error("update too early");
   property p_update_count;
      o_update |-> $past(st_reg.busy) && $past(st_reg.edge_cnt) == CW'(UPDATE_HALF_EDGES - 1) &&
         ($past(rise) || $past(fall));
   endproperty
   a_update_count: assert property (p_update_count) else $error("update not after count");
   property p_in_phase;
      ($changed(o_left_sample) || $changed(o_right_sample)) |-> o_update &&
         o_left_sample == $past(st_reg.head.left) && o_right_sample == $past(st_reg.head.right);
   endproperty
   a_in_phase: assert property (p_in_phase) else $error("channels not updated together");
endmodule : stereo_dac_serial_input

// file: verification/audio_source_model.sv
/*
 * Behavioural sample source: bit clock, strobe and data lines.
 * Assumes the bench calls one task at a time; clock idles low.
 */
`timescale 1ns/1ps
module audio_source_model (
   output logic o_bit_clock,
   output logic o_strobe,
   output logic o_data_l,
   output logic o_pol_or_r,
   output logic o_format
);
   logic    pol;
   realtime t_end;

   // ------
   // Link tasks
   // ------
   initial
   begin
      {o_bit_clock, o_strobe, o_data_l, o_pol_or_r, o_format, pol} = '0;
   end

   task automatic setup(input logic f, input logic p);
   begin
      o_format = f;
      pol = p;
   end
   endtask : setup

   // one bit per clock, lines change on the fall
   task automatic bit_out(input logic s, input logic d, input logic r);
   begin
      o_bit_clock = 1'b0;
      o_strobe = s;
      o_data_l = d;
      o_pol_or_r = o_format ? r : pol;
      #100 o_bit_clock = 1'b1;
      #100;
   end
   endtask : bit_out

   // MSB first, left slot level set by polarity
   task automatic word(input logic [15:0] l, input logic [15:0] r, input logic left);
   begin
      for (int i = 15; i >= 0; i--)
         bit_out(o_format ? (i < 12) : (left ^ pol), l[i], r[i]);
   end
   endtask : word

   task automatic pair(input logic [15:0] l, input logic [15:0] r);
   begin
      if (o_format)
         word(l, r, 1'b1);
      else
      begin
         word(l, 16'h0000, 1'b1);
         word(r, 16'h0000, 1'b0);
      end
   end
   endtask : pair

   // Released data toggles so a stale bit never looks valid
   task automatic tail(input int n);
   begin
      t_end = $realtime + 100;
      for (int i = 0; i < n; i++)
         bit_out(o_format ? 1'b0 : ~pol, ~o_data_l, ~o_pol_or_r);
      o_bit_clock = 1'b0;
   end
   endtask : tail
endmodule : audio_source_model

// file: verification/tb_stereo_dac_serial_input.sv
/*
 * Self-checking bench for the serial sample input front end.
 * Assumes the source model drives the link pins, the bench the rest.
 */
`timescale 1ns/1ps
`define CHECK(nm, e, g) \
   begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_stereo_dac_serial_input;
   logic                  i_mclk = 1'b0;
   logic                  i_rst = 1'b1;
   logic                  ready = 1'b1;
   logic                  bclk, strobe, dl, pr, fmt, upd, ovr;
   logic [15:0]           left_s, right_s, pl, prs;
   int                    mismatches = 0, comparisons = 0, overruns = 0;
   dac_serial_pkg::pair_t got[$];
   realtime               t_upd;
   logic [15:0]           vals [6] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff, 16'ha5c3, 16'h5a3c};

   always #12.5 i_mclk = ~i_mclk;

   audio_source_model src (.o_bit_clock(bclk), .o_strobe(strobe), .o_data_l(dl),
      .o_pol_or_r(pr), .o_format(fmt));
   stereo_dac_serial_input dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_bit_clock(bclk),
      .i_channel_word_strobe(strobe), .i_shared_or_left_serial_input(dl),
      .i_polarity_or_right_input(pr), .i_format_select(fmt), .i_dac_ready(ready),
      .o_left_sample(left_s), .o_right_sample(right_s), .o_update(upd), .o_overrun(ovr));

   // ------
   // Monitor: collect updates; outputs may move only with the pulse
   // ------
   always @(negedge i_mclk)
   begin
      if (!i_rst && upd !== 1'b1)
         `CHECK("held pair", {pl, prs}, {left_s, right_s})
      if (upd === 1'b1)
      begin
         got.push_back({left_s, right_s});
         t_upd = $realtime;
      end
      overruns += int'(ovr === 1'b1);
      {pl, prs} = {left_s, right_s};
   end

   task automatic stop_test;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask : stop_test

   task automatic do_reset(input logic f, input logic p);
   begin
      src.setup(f, p);
      @(negedge i_mclk) i_rst = 1'b1;
      repeat (20) @(negedge i_mclk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      `CHECK("reset pair", 32'h0, {left_s, right_s})
      got.delete();
      overruns = 0;
   end
   endtask : do_reset

   task automatic check_back(input int back, input logic [15:0] l, input logic [15:0] r);
      int idx;
   begin
      idx = got.size() - 1 - back;
      `CHECK("left word", l, got[idx].left)
      `CHECK("right word", r, got[idx].right)
   end
   endtask : check_back

   // ------
   // Scenarios
   // ------
   // Back-to-back pairs with boundary words, then the update delay
   task automatic test_stream(input logic f, input logic p);
   begin
      do_reset(f, p);
      for (int i = 0; i < 3; i++)
         src.pair(vals[2*i] ^ {14'h0, f, p}, vals[2*i+1] ^ {14'h0, p, f});
      src.tail(12);
      `CHECK("update count", 3, got.size())
      for (int i = 0; i < 3; i++)
         check_back(2 - i, vals[2*i] ^ {14'h0, f, p}, vals[2*i+1] ^ {14'h0, p, f});
      `CHECK("update delay", 1'b1, (t_upd - src.t_end >= 875) && (t_upd - src.t_end <= 1175))
      $display("test stream format %0d polarity %0d done", f, p);
   end
   endtask : test_stream

   // Stall the converter side until the buffer refuses, then drain it
   task automatic test_overrun;
   begin
      do_reset(1'b1, 1'b0);
      @(negedge i_mclk) ready = 1'b0;
      for (int i = 0; i < 34; i++)
         src.pair(16'h8000 | 16'(i), 16'h0100 * 16'(i));
      src.tail(2);
      `CHECK("stalled updates", 0, got.size())
      @(negedge i_mclk) ready = 1'b1;
      src.tail(220);
      `CHECK("drained count", 33, got.size())
      `CHECK("overrun pulses", 1, overruns)
      check_back(32, 16'h8000, 16'h0000);
      check_back(0, 16'h8020, 16'h2000);
      $display("test overrun done");
   end
   endtask : test_overrun

   initial
   begin
      test_overrun();
      test_stream(1'b1, 1'b0);
      test_stream(1'b0, 1'b1);
      test_stream(1'b0, 1'b0);
      stop_test();
   end

   // Hang guard
   initial
   begin
      #1_000_000;
      mismatches++;
      stop_test();
   end
endmodule : tb_stereo_dac_serial_input
